// *** include/mac_fc_consts.svh ***
`ifndef MAC_FC_CONSTS_SVH
`define MAC_FC_CONSTS_SVH
// Contract
// - Inverse bit flips destination match outcome
// - Promiscuous forwards all, clears filter fails
// - Access addresses PHY 0-31 and register
// - Management clock divides system clock 42/26
// - Write bit sends data, else reads
// - Busy set by software, cleared on completion
// - Data register holds 16 management bits
// - Pause quanta field goes into pause frame
// - Retransmit pause at quanta minus threshold if receive FIFO above on or full
// - Slot time equals 512 bit times
// - Reserved multicast always, station optionally
// - Receive flow enable honours pause frames
// - Transmit flow enable gates pause, backpressure
// - Flow busy set, held, cleared after send in full duplex
// - Half duplex busy jams new frames
// - Transmit controller state encodes four states
// - Receive fill status encodes four levels
// - Low-power transitions set event, read clears
// - Wake frames set event, status read clears
// - Pause needs type 8808, opcode 0001

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_FILTER 16'h1004
`define REG_MGMT_ADDR 16'h1010
`define REG_MGMT_DATA 16'h1014
`define REG_FLOW 16'h1018
`define REG_DEBUG 16'h1024
`define REG_PM_STATUS 16'h102c
`define REG_LPI_CTRL 16'h1030
`define REG_EVENT 16'h1038

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FILT_PROM_BIT 0
`define FILT_INV_BIT 3
`define LPI_EN_BIT 16
`define PM_MAGIC_BIT 5
`define PM_WAKE_BIT 6
`define EVT_WAKE_BIT 3
`define EVT_LPI_BIT 10

// ----------------------------------------
// Timing and protocol values
// ----------------------------------------
`define SYS_MHZ 25
`define MDC_DIV ((`SYS_MHZ >= 60) ? 42 : 26)
`define MDC_HALF (`MDC_DIV / 2)
`define SLOT_BITS 512
`define MGMT_BITS 64
`define MGMT_DRIVE_RD 46
`define MGMT_DATA_FIRST 48
`define THR_CODE0 9'd4
`define THR_CODE1 9'd28
`define THR_CODE2 9'd144
`define THR_CODE3 9'd256
`define PAUSE_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** include/mac_fc_pkg.sv ***
package mac_fc_pkg;
  typedef enum logic [1:0] {MG_IDLE = 2'b01, MG_SHIFT = 2'b10} mgmt_state_t;
  typedef enum logic [1:0] {
    TXC_IDLE = 2'b00, TXC_WAIT = 2'b01, TXC_PAUSE = 2'b10, TXC_XFER = 2'b11
  } tx_ctrl_state_t;
  typedef enum logic [1:0] {
    FILL_EMPTY = 2'b00, FILL_BELOW = 2'b01, FILL_ABOVE = 2'b10, FILL_FULL = 2'b11
  } fill_level_t;
  typedef struct packed {
    logic [15:0] pause_quanta;
    logic [9:0] unused;
    logic [1:0] pause_low_threshold;
    logic unicast_pause_detect;
    logic rx_flow_ctrl_enable;
    logic tx_flow_ctrl_enable;
    logic pause_request_busy;
  } flow_reg_t;
  typedef struct packed {
    logic [15:0] unused;
    logic [4:0] phy_select;
    logic [4:0] phy_register_select;
    logic [3:0] mgmt_clock_range;
    logic mgmt_write_select;
    logic mgmt_busy_flag;
  } mgmt_addr_t;
endpackage

// *** hdl/mac_flow_mgmt_status_ctrl.sv ***
`include "mac_fc_consts.svh"
module mac_flow_mgmt_status_ctrl (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_N,
  input wire logic FULL_DUPLEX,
  input wire logic BIT_TICK,
  input wire logic RX_DONE,
  input wire logic RX_DA_MATCH,
  input wire logic RX_SA_FAIL_IN,
  input wire logic RX_DA_RESERVED,
  input wire logic RX_DA_STATION0,
  input wire logic [15:0] RX_TYPE,
  input wire logic [15:0] RX_OPCODE,
  input wire logic [15:0] RX_PAUSE_VAL,
  output logic RX_ACCEPT,
  output logic RX_DA_FAIL,
  output logic RX_SA_FAIL,
  input wire logic RX_FRAME_START,
  output logic JAM_REQ,
  output logic BACKPRESSURE,
  output logic TX_HALT,
  output logic TX_PAUSE_REQ,
  output logic [15:0] TX_PAUSE_QUANTA,
  input wire logic TX_PAUSE_SENT,
  input wire logic TX_XFER,
  input wire logic TX_WAIT,
  input wire logic [1:0] TX_FIFO_RD_STATE,
  input wire logic [1:0] RX_FIFO_RD_STATE,
  input wire logic RX_FIFO_EMPTY,
  input wire logic RX_FIFO_ABOVE_ON,
  input wire logic RX_FIFO_FULL,
  input wire logic TX_LPI,
  input wire logic RX_LPI,
  input wire logic POWER_DOWN,
  input wire logic MAGIC_RX,
  input wire logic WAKEUP_RX,
  output logic WAKE_EVENT,
  output logic LPI_EVENT
);
  localparam int HALF_M1 = `MDC_HALF - 1;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_fire, rd_fire, wr_mapped, rd_mapped;
  logic [31:0] wmask, rd_mux;
  logic filt_wr, mga_wr, mgd_wr, flow_wr, lpi_wr, rd_lpi, rd_pm;
  assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_fire = S_AXI_ARVALID && !S_AXI_RVALID;
  assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                  {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
  assign filt_wr = wr_fire && S_AXI_AWADDR == `REG_FILTER;
  assign mga_wr = wr_fire && S_AXI_AWADDR == `REG_MGMT_ADDR;
  assign mgd_wr = wr_fire && S_AXI_AWADDR == `REG_MGMT_DATA;
  assign flow_wr = wr_fire && S_AXI_AWADDR == `REG_FLOW;
  assign lpi_wr = wr_fire && S_AXI_AWADDR == `REG_LPI_CTRL;
  assign rd_lpi = rd_fire && S_AXI_ARADDR == `REG_LPI_CTRL;
  assign rd_pm = rd_fire && S_AXI_ARADDR == `REG_PM_STATUS;
  assign wr_mapped = filt_wr || mga_wr || mgd_wr || flow_wr || lpi_wr;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic prom, inv_filter, lpi_en;
  logic [15:0] mgmt_data, rd_shift;
  mac_fc_pkg::mgmt_addr_t mga, mga_new;
  mac_fc_pkg::flow_reg_t flow, flow_new;
  mac_fc_pkg::mgmt_state_t mstate;
  logic mgmt_done, pause_done, pause_pend, retransmit;
  assign mga_new = (mga & ~wmask) | (S_AXI_WDATA & wmask);
  assign flow_new = (flow & ~wmask) | (S_AXI_WDATA & wmask);

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      prom <= 1'b0;
      inv_filter <= 1'b0;
      lpi_en <= 1'b0;
    end else begin
      if (filt_wr && S_AXI_WSTRB[0]) begin
        prom <= S_AXI_WDATA[`FILT_PROM_BIT];
        inv_filter <= S_AXI_WDATA[`FILT_INV_BIT];
      end
      if (lpi_wr && S_AXI_WSTRB[2]) begin
        lpi_en <= S_AXI_WDATA[`LPI_EN_BIT];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mga <= '0;
    end else if (mga_wr && !mga.mgmt_busy_flag) begin
      mga <= mga_new;
    end else if (mgmt_done) begin
      mga.mgmt_busy_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mgmt_data <= 16'h0000;
    end else if (mgmt_done && !mga.mgmt_write_select) begin
      mgmt_data <= rd_shift;
    end else if (mgd_wr && !mga.mgmt_busy_flag) begin
      mgmt_data <= (mgmt_data & ~wmask[15:0]) | (S_AXI_WDATA[15:0] & wmask[15:0]);
    end
  end

  // Busy self-clears only in full duplex; half duplex keeps it plain
  assign pause_done = TX_PAUSE_SENT || (!flow.tx_flow_ctrl_enable && !flow_wr);
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      flow <= '0;
    end else begin
      if (flow_wr) begin
        flow <= flow_new;
      end
      if (flow_wr && flow_new.pause_request_busy) begin
        flow.pause_request_busy <= 1'b1;
      end else if (FULL_DUPLEX) begin
        flow.pause_request_busy <= flow.pause_request_busy && !pause_done;
      end else if (flow_wr) begin
        flow.pause_request_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  logic tx_lpi_d, rx_lpi_d, pm_magic, pm_wake;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      tx_lpi_d <= 1'b0;
      rx_lpi_d <= 1'b0;
      LPI_EVENT <= 1'b0;
      pm_magic <= 1'b0;
      pm_wake <= 1'b0;
    end else begin
      tx_lpi_d <= TX_LPI;
      rx_lpi_d <= RX_LPI;
      // entry or exit sets, read clears
      LPI_EVENT <= (lpi_en && ((TX_LPI ^ tx_lpi_d) || (RX_LPI ^ rx_lpi_d)))
                   || (LPI_EVENT && !rd_lpi);
      pm_magic <= (POWER_DOWN && MAGIC_RX) || (pm_magic && !rd_pm);
      pm_wake <= (POWER_DOWN && WAKEUP_RX) || (pm_wake && !rd_pm);
    end
  end
  assign WAKE_EVENT = pm_magic || pm_wake;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  mac_fc_pkg::tx_ctrl_state_t txc;
  mac_fc_pkg::fill_level_t fill;
  always_comb begin
    rd_mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      `REG_FILTER: begin
        rd_mux[`FILT_PROM_BIT] = prom;
        rd_mux[`FILT_INV_BIT] = inv_filter;
      end
      `REG_MGMT_ADDR: rd_mux = mga;
      `REG_MGMT_DATA: rd_mux = {16'h0000, mgmt_data};
      `REG_FLOW: rd_mux = flow;
      `REG_DEBUG: rd_mux = {10'h000, TX_FIFO_RD_STATE, 1'b0, txc, 7'h00,
                            fill, 1'b0, RX_FIFO_RD_STATE, 5'h00};
      `REG_PM_STATUS: begin
        rd_mux[`PM_MAGIC_BIT] = pm_magic;
        rd_mux[`PM_WAKE_BIT] = pm_wake;
      end
      `REG_LPI_CTRL: begin
        rd_mux[0] = LPI_EVENT;
        rd_mux[`LPI_EN_BIT] = lpi_en;
      end
      `REG_EVENT: begin
        rd_mux[`EVT_WAKE_BIT] = WAKE_EVENT;
        rd_mux[`EVT_LPI_BIT] = LPI_EVENT;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive address filter
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RX_ACCEPT <= 1'b0;
      RX_DA_FAIL <= 1'b0;
      RX_SA_FAIL <= 1'b0;
    end else if (RX_DONE) begin
      if (prom) begin
        RX_ACCEPT <= 1'b1;
        RX_DA_FAIL <= 1'b0;
        RX_SA_FAIL <= 1'b0;
      end else begin
        RX_DA_FAIL <= inv_filter ? RX_DA_MATCH : !RX_DA_MATCH;
        RX_SA_FAIL <= RX_SA_FAIL_IN;
        RX_ACCEPT <= (inv_filter ? !RX_DA_MATCH : RX_DA_MATCH) && !RX_SA_FAIL_IN;
      end
    end
  end

  // ----------------------------------------
  // Pause timing
  // ----------------------------------------
  logic [8:0] bit_cnt, thr;
  logic slot_tick, rx_pause, rt_armed;
  logic [15:0] halt_cnt, rt_slots, rt_limit;
  assign slot_tick = BIT_TICK && bit_cnt == 9'(`SLOT_BITS - 1);
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bit_cnt <= 9'h000;
    end else if (BIT_TICK) begin
      bit_cnt <= bit_cnt + 9'h001;
    end
  end

  assign rx_pause = RX_DONE && FULL_DUPLEX && flow.rx_flow_ctrl_enable
                    && RX_TYPE == `PAUSE_TYPE && RX_OPCODE == `PAUSE_OPCODE
                    && (RX_DA_RESERVED || (flow.unicast_pause_detect && RX_DA_STATION0));
  // halt transmitter for the pause time
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !flow.rx_flow_ctrl_enable) begin
      halt_cnt <= 16'h0000;
    end else if (rx_pause) begin
      halt_cnt <= RX_PAUSE_VAL;
    end else if (slot_tick && halt_cnt != 16'h0000) begin
      halt_cnt <= halt_cnt - 16'h0001;
    end
  end
  assign TX_HALT = halt_cnt != 16'h0000;

  always_comb begin
    unique case (flow.pause_low_threshold)
      2'b00: thr = `THR_CODE0;
      2'b01: thr = `THR_CODE1;
      2'b10: thr = `THR_CODE2;
      2'b11: thr = `THR_CODE3;
    endcase
  end
  // Quanta at or below threshold retransmits at once if receive FIFO is above on or full
  assign rt_limit = (flow.pause_quanta > {7'h00, thr}) ?
                    flow.pause_quanta - {7'h00, thr} : 16'h0000;
  assign retransmit = rt_armed && rt_slots == rt_limit
                      && (RX_FIFO_ABOVE_ON || RX_FIFO_FULL);
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rt_armed <= 1'b0;
      rt_slots <= 16'h0000;
    end else if (TX_PAUSE_SENT) begin
      rt_armed <= 1'b1;
      rt_slots <= 16'h0000;
    end else if (retransmit || rt_slots >= rt_limit) begin
      rt_armed <= 1'b0;
    end else if (slot_tick) begin
      rt_slots <= rt_slots + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pause_pend <= 1'b0;
    end else if ((flow_wr && flow_new.pause_request_busy && FULL_DUPLEX) || retransmit) begin
      pause_pend <= 1'b1;
    end else if (pause_done || !FULL_DUPLEX) begin
      pause_pend <= 1'b0;
    end
  end
  assign TX_PAUSE_REQ = pause_pend && FULL_DUPLEX && flow.tx_flow_ctrl_enable;
  assign TX_PAUSE_QUANTA = flow.pause_quanta;

  assign BACKPRESSURE = !FULL_DUPLEX && flow.pause_request_busy && flow.tx_flow_ctrl_enable;
  assign JAM_REQ = BACKPRESSURE && RX_FRAME_START;

  always_comb begin
    if (TX_PAUSE_REQ) txc = mac_fc_pkg::TXC_PAUSE;
    else if (TX_XFER) txc = mac_fc_pkg::TXC_XFER;
    else if (TX_WAIT) txc = mac_fc_pkg::TXC_WAIT;
    else txc = mac_fc_pkg::TXC_IDLE;
    if (RX_FIFO_FULL) fill = mac_fc_pkg::FILL_FULL;
    else if (RX_FIFO_ABOVE_ON) fill = mac_fc_pkg::FILL_ABOVE;
    else if (RX_FIFO_EMPTY) fill = mac_fc_pkg::FILL_EMPTY;
    else fill = mac_fc_pkg::FILL_BELOW;
  end

  // ----------------------------------------
  // Management serial engine
  // ----------------------------------------
  logic [7:0] dcnt;
  logic [5:0] bitn;
  logic [63:0] shreg;
  logic start;
  assign start = mga_wr && !mga.mgmt_busy_flag && mga_new.mgmt_busy_flag;
  assign mgmt_done = mstate == mac_fc_pkg::MG_SHIFT && dcnt == 8'(HALF_M1)
                     && MDC && bitn == 6'(`MGMT_BITS - 1);
  assign MDIO_O = shreg[63];

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mstate <= mac_fc_pkg::MG_IDLE;
      MDC <= 1'b0;
      MDIO_OE_N <= 1'b1;
      dcnt <= 8'h00;
      bitn <= 6'h00;
      shreg <= {64{1'b1}};
      rd_shift <= 16'h0000;
    end else begin
      unique case (mstate)
        mac_fc_pkg::MG_IDLE: begin
          if (start) begin
            // preamble, start, op, addresses, turnaround, data
            shreg <= {32'hffff_ffff, 2'b01,
                      mga_new.mgmt_write_select ? 2'b01 : 2'b10,
                      mga_new.phy_select, mga_new.phy_register_select,
                      mga_new.mgmt_write_select ? {2'b10, mgmt_data} : 18'h3ffff};
            mstate <= mac_fc_pkg::MG_SHIFT;
            MDIO_OE_N <= 1'b0;
            dcnt <= 8'h00;
            bitn <= 6'h00;
            MDC <= 1'b0;
          end
        end
        mac_fc_pkg::MG_SHIFT: begin
          if (dcnt == 8'(HALF_M1)) begin
            dcnt <= 8'h00;
            MDC <= !MDC;
            if (MDC) begin
              shreg <= {shreg[62:0], 1'b1};
              bitn <= bitn + 6'h01;
              MDIO_OE_N <= !(mga.mgmt_write_select
                             || bitn < 6'(`MGMT_DRIVE_RD - 1));
              if (mgmt_done) begin
                // Missing PHY still completes; read gives all ones
                mstate <= mac_fc_pkg::MG_IDLE;
                MDIO_OE_N <= 1'b1;
              end
            end else if (bitn >= 6'(`MGMT_DATA_FIRST)) begin
              rd_shift <= {rd_shift[14:0], MDIO_I};
            end
          end else begin
            dcnt <= dcnt + 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence s_last_edge;
    mstate == mac_fc_pkg::MG_SHIFT && mgmt_done;
  endsequence
  sequence s_idle_free;
    mstate == mac_fc_pkg::MG_IDLE && !mga.mgmt_busy_flag;
  endsequence

  property p_prom_pass;
    RX_DONE && prom |=> RX_ACCEPT && !RX_DA_FAIL && !RX_SA_FAIL;
  endproperty
  a_prom_pass: assert property (p_prom_pass) else $error("promiscuous frame not passed");

  property p_inverse;
    RX_DONE && !prom && inv_filter |=> RX_DA_FAIL == $past(RX_DA_MATCH);
  endproperty
  a_inverse: assert property (p_inverse) else $error("inverse filter wrong");

  property p_mdc_half;
    $rose(MDC) |-> ##HALF_M1 MDC ##1 !MDC;
  endproperty
  a_mdc_half: assert property (p_mdc_half) else $error("management clock half wrong");

  property p_busy_hold;
    mstate == mac_fc_pkg::MG_SHIFT |-> mga.mgmt_busy_flag;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped mid access");

  property p_busy_clear;
    s_last_edge |=> s_idle_free;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared at end");

  property p_write_drive;
    mstate == mac_fc_pkg::MG_SHIFT && mga.mgmt_write_select |-> !MDIO_OE_N;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write not driven");

  property p_fcb_clear;
    TX_PAUSE_SENT && FULL_DUPLEX && !flow_wr |=> !flow.pause_request_busy;
  endproperty
  a_fcb_clear: assert property (p_fcb_clear) else $error("flow busy not cleared");

  property p_no_pause_off;
    !flow.tx_flow_ctrl_enable |-> !TX_PAUSE_REQ && !BACKPRESSURE;
  endproperty
  a_no_pause_off: assert property (p_no_pause_off) else $error("pause with flow off");

  property p_halt;
    rx_pause && RX_PAUSE_VAL != 16'h0000 |=> TX_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("pause frame not honoured");

  property p_bp_half;
    BACKPRESSURE |-> !FULL_DUPLEX;
  endproperty
  a_bp_half: assert property (p_bp_half) else $error("backpressure in full duplex");

  property p_lpi_set;
    lpi_en && $rose(TX_LPI) |=> LPI_EVENT;
  endproperty
  a_lpi_set: assert property (p_lpi_set) else $error("low-power event missed");
endmodule

// *** testbench/phy_model.sv ***
module phy_model (
  input wire logic mdc,
  input wire logic mdo,
  input wire logic oe_n,
  input wire logic present,
  input wire logic [15:0] rd_val,
  output logic mdi,
  output logic [63:0] frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt = 6'h00;
  logic drv = 1'b0;
  logic bit_o = 1'b1;
  always @(posedge mdc) begin
    frame <= {frame[62:0], mdi};
    cnt <= cnt + 6'h01;
  end
  always @(negedge mdc) begin
    drv <= present && cnt >= 6'd47;
    bit_o <= (cnt == 6'd47) ? 1'b0 : rd_val[6'd63 - cnt];
  end
  // Pull-up holds a released line high
  assign mdi = !oe_n ? mdo : (drv ? bit_o : 1'b1);
endmodule

// *** testbench/tb_mac_flow_mgmt_status_ctrl.sv ***
module tb_mac_flow_mgmt_status_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] S_AXI_AWADDR = 16'h0000, S_AXI_ARADDR = 16'h0000;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd, d;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  logic MDC, MDIO_I, MDIO_O, MDIO_OE_N, RX_ACCEPT, RX_DA_FAIL, RX_SA_FAIL;
  logic JAM_REQ, BACKPRESSURE, TX_HALT, TX_PAUSE_REQ, WAKE_EVENT, LPI_EVENT;
  logic [15:0] TX_PAUSE_QUANTA;
  logic FULL_DUPLEX = 1'b1, BIT_TICK = 1'b1, RX_DONE = 1'b0, RX_DA_MATCH = 1'b0;
  logic RX_SA_FAIL_IN = 1'b0, RX_DA_RESERVED = 1'b0, RX_DA_STATION0 = 1'b0;
  logic [15:0] RX_TYPE = 16'h0, RX_OPCODE = 16'h0, RX_PAUSE_VAL = 16'h0;
  logic RX_FRAME_START = 1'b0, TX_PAUSE_SENT = 1'b0, TX_XFER = 1'b0, TX_WAIT = 1'b0;
  logic [1:0] TX_FIFO_RD_STATE = 2'b00, RX_FIFO_RD_STATE = 2'b00;
  logic RX_FIFO_EMPTY = 1'b1, RX_FIFO_ABOVE_ON = 1'b0, RX_FIFO_FULL = 1'b0;
  logic TX_LPI = 1'b0, RX_LPI = 1'b0, POWER_DOWN = 1'b0, MAGIC_RX = 1'b0;
  logic WAKEUP_RX = 1'b0, present = 1'b1;
  logic [15:0] rd_val = 16'h0;
  logic [63:0] frame;
  logic [15:0] regs [5] = '{16'h1004, 16'h1010, 16'h1014, 16'h1018, 16'h1030};
  logic [6:0] pc [6] = '{7'h6b, 7'h2a, 7'h29, 7'h0b, 7'h27, 7'h77};
  integer n_errors = 0, samples_checked = 0, seed = 76, cyc = 0, i, k;
  time t_rise = 0, period = 0;

  mac_flow_mgmt_status_ctrl u_dut (.*);
  phy_model u_phy (.mdc(MDC), .mdo(MDIO_O), .oe_n(MDIO_OE_N), .present(present),
    .rd_val(rd_val), .mdi(MDIO_I), .frame(frame));

  // ------
  // Helpers
  // ------
  initial forever #20 CLK_SYS = ~CLK_SYS;
  always @(posedge MDC) begin
    period = $time - t_rise;
    t_rise = $time;
  end
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do @(posedge CLK_SYS); while (S_AXI_AWREADY !== 1'b1 || S_AXI_WREADY !== 1'b1);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
    rs = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rdr(input logic [15:0] a, output logic [31:0] v);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
    v = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic wait_busy();
    k = 0;
    do begin
      rdr(16'h1010, rd);
      k++;
    end while (rd[0] !== 1'b0 && k < 1000);
    // poll limit counts as a miss
    check(32'(rd[0]), 32'h0);
  endtask
  task automatic summarize();
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    repeat (8) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    for (i = 0; i < 5; i++) begin
      rdr(regs[i], rd);
      check(rd, 32'h0);
    end
    rdr(16'h1000, rd);
    check({rd[29:0], rs}, 32'h2);
    wr(16'h1024, 32'h0);
    check(32'(rs), 32'h2);
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      wr(16'h1004, {28'h0, d[3], 2'b00, d[0]});
      RX_DA_MATCH <= d[4];
      RX_SA_FAIL_IN <= d[5];
      RX_DONE <= 1'b1;
      @(posedge CLK_SYS);
      RX_DONE <= 1'b0;
      @(posedge CLK_SYS);
      check(32'(RX_DA_FAIL), 32'(!d[0] && (d[4] == d[3])));
      check(32'({RX_SA_FAIL, RX_ACCEPT | !d[0]}), 32'({!d[0] && d[5], 1'b1}));
    end
    $display("test filter done");
    d = $random(seed);
    wr(16'h1014, {16'h0, d[15:0]});
    wr(16'h1010, {16'h0, d[20:16], d[25:21], 4'h0, 2'b11});
    rdr(16'h1010, rd);
    check(32'(rd[0]), 32'h1);
    wr(16'h1014, 32'h0000_5a5a);
    wait_busy();
    check(frame[63:32], 32'hffff_ffff);
    check(frame[31:0], {2'b01, 2'b01, d[20:16], d[25:21], 2'b10, d[15:0]});
    check(period[31:0], 32'd1040);
    rdr(16'h1014, rd);
    check(rd, {16'h0, d[15:0]});
    for (i = 0; i < 2; i++) begin
      present <= (i == 0);
      rd_val <= d[31:16];
      wr(16'h1010, {16'h0, d[4:0], d[9:5], 4'h0, 2'b01});
      wait_busy();
      check(32'(frame[31:18]), 32'({4'b0110, d[4:0], d[9:5]}));
      rdr(16'h1014, rd);
      check(rd, {16'h0, (i == 0) ? d[31:16] : 16'hffff});
    end
    $display("test mgmt done");
    d = $random(seed);
    wr(16'h1018, {d[31:16], 14'h0, 2'b11});
    check({TX_PAUSE_QUANTA, 15'h0, TX_PAUSE_REQ}, {d[31:16], 16'h1});
    rdr(16'h1018, rd);
    check(32'(rd[0]), 32'h1);
    rdr(16'h1024, rd);
    check(32'(rd[18:17]), 32'h2);
    TX_PAUSE_SENT <= 1'b1;
    @(posedge CLK_SYS);
    TX_PAUSE_SENT <= 1'b0;
    @(posedge CLK_SYS);
    rdr(16'h1018, rd);
    check(32'({rd[0], TX_PAUSE_REQ}), 32'h0);
    wr(16'h1018, {d[31:16], 14'h0, 2'b01});
    rdr(16'h1018, rd);
    check(32'({rd[0], TX_PAUSE_REQ}), 32'h0);
    $display("test pause tx done");
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      TX_XFER <= (i == 3);
      TX_WAIT <= (i == 1);
      RX_FIFO_EMPTY <= (i == 0);
      RX_FIFO_ABOVE_ON <= (i == 2);
      RX_FIFO_FULL <= (i == 3);
      TX_FIFO_RD_STATE <= d[1:0];
      RX_FIFO_RD_STATE <= d[3:2];
      @(posedge CLK_SYS);
      rdr(16'h1024, rd);
      check(32'({rd[21:20], rd[18:17]}), 32'({d[1:0], i == 3, i[0]}));
      check(32'({rd[9:8], rd[6:5]}), 32'({i[1:0], d[3:2]}));
    end
    $display("test debug done");
    for (i = 0; i < 6; i++) begin
      wr(16'h1018, {28'h0, pc[i][4], pc[i][5], 2'b00});
      {RX_DA_RESERVED, RX_DA_STATION0} <= pc[i][3:2];
      RX_TYPE <= pc[i][1] ? 16'h8808 : 16'h8809;
      RX_OPCODE <= pc[i][0] ? 16'h0001 : 16'h0002;
      // Two slots: slot phase is free running, one window sees one tick
      RX_PAUSE_VAL <= 16'h0002;
      RX_DONE <= 1'b1;
      @(posedge CLK_SYS);
      RX_DONE <= 1'b0;
      repeat (500) @(posedge CLK_SYS);
      check(32'(TX_HALT), 32'(pc[i][6]));
      repeat (530) @(posedge CLK_SYS);
      check(32'(TX_HALT), 32'h0);
    end
    $display("test pause rx done");
    wr(16'h1030, 32'h0001_0000);
    TX_LPI <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    check(32'(LPI_EVENT), 32'h1);
    rdr(16'h1030, rd);
    check(32'({rd[16], rd[0], LPI_EVENT}), 32'h6);
    POWER_DOWN <= 1'b1;
    MAGIC_RX <= 1'b1;
    @(posedge CLK_SYS);
    MAGIC_RX <= 1'b0;
    @(posedge CLK_SYS);
    check(32'(WAKE_EVENT), 32'h1);
    rdr(16'h102c, rd);
    check(32'({rd[6:5], WAKE_EVENT}), 32'h2);
    $display("test events done");
    FULL_DUPLEX <= 1'b0;
    wr(16'h1018, 32'h0000_0003);
    RX_FRAME_START <= 1'b1;
    @(negedge CLK_SYS);
    check(32'({BACKPRESSURE, JAM_REQ}), 32'h3);
    @(posedge CLK_SYS);
    RX_FRAME_START <= 1'b0;
    FULL_DUPLEX <= 1'b1;
    @(negedge CLK_SYS);
    check(32'(BACKPRESSURE), 32'h0);
    $display("test backpressure done");
    summarize();
  end
endmodule
